// ### logic/sct_second_trim.sv
// sct_second_trim.sv: compensated one-second tick from a 32768 Hz clock
// assumes: clk is the oscillator clock, config writes come on the same clock
//
// Function
// - divide oscillator by 32768 per second
// - one config word holds interval and value
// - interval is unsigned seconds 1 to 255
// - value is signed cycles -128 to 127
// - zero interval or value disables compensation
// - adjust first second, restart after interval
// - first second changes by signed value
// - other seconds last exactly 32768 cycles
// - tick drives output pin when enabled
// - pin pulse high for one cycle
`timescale 1ns/10ps
`default_nettype none
`include "sct_params.svh"

module sct_second_trim (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// drift_trim_config access
	input wire logic cfg_we,
	input wire logic [`SCT_CFG_W-1:0] cfg_wdata,
	output logic [`SCT_CFG_W-1:0] cfg_rdata,
	// pin output control
	input wire logic pin_enable,
	// tick outputs
	output logic second_tick,
	output logic second_pulse_pin
);

	////////////////////////////////////////////////////////////////////////
	// configuration

	logic load_active;
	logic [`SCT_CFG_W-1:0] cfg_active;

	sct_cfg_latch u_cfg (
		.clk(clk),
		.rstn(rstn),
		.cfg_we(cfg_we),
		.cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata),
		.load_active(load_active),
		.cfg_active(cfg_active)
	);

	// fields of the active copy
	wire sct_pkg::sct_intv_t intv = cfg_active[`SCT_INTV_MSB:`SCT_INTV_LSB];
	wire sct_pkg::sct_val_t val = cfg_active[`SCT_VAL_MSB:`SCT_VAL_LSB];
	wire comp_on = (intv != 8'h00) && (val != 8'h00);

	////////////////////////////////////////////////////////////////////////
	// second length

	// cycles in the second, as last count value (length minus one)
	function automatic sct_pkg::sct_cnt_t last_count(input logic adj,
		input sct_pkg::sct_val_t v);
		logic signed [`SCT_CNT_W+1:0] len;
		len = (`SCT_CNT_W+2)'(`SCT_SECOND_CYCLES - 1);
		if (adj) begin
			len = len + {{(`SCT_CNT_W-6){v[7]}}, v};
		end
		last_count = len[`SCT_CNT_W-1:0];
	endfunction

	sct_pkg::sct_cnt_t cnt_r;
	sct_pkg::sct_cnt_t cnt_nxt;
	sct_pkg::sct_intv_t sec_r;
	sct_pkg::sct_intv_t sec_nxt;
	sct_pkg::sct_phase_e phase_r;
	sct_pkg::sct_phase_e phase_nxt;
	logic tick_r;
	logic pin_r;

	// only the first second of an interval carries the adjustment
	wire adj_now = (phase_r == sct_pkg::SCT_FIRST) && comp_on;
	wire sec_end = (cnt_r == last_count(adj_now, val));
	// interval complete: last second of the programmed count
	wire intv_end = sec_end && ((sec_r + 8'h01) >= intv);

	////////////////////////////////////////////////////////////////////////
	// interval sequencing

	// next cycle and second counters
	always_comb begin
		cnt_nxt = sec_end ? '0 : cnt_r + 16'h0001;
		sec_nxt = sec_r;
		phase_nxt = phase_r;
		case (phase_r)
			sct_pkg::SCT_FIRST: begin
				if (intv_end) begin
					sec_nxt = 8'h00;
					phase_nxt = sct_pkg::SCT_FIRST;
				end else if (sec_end) begin
					sec_nxt = 8'h01;
					phase_nxt = sct_pkg::SCT_OTHER;
				end
			end
			sct_pkg::SCT_OTHER: begin
				if (intv_end) begin
					sec_nxt = 8'h00;
					phase_nxt = sct_pkg::SCT_FIRST;
				end else if (sec_end) begin
					sec_nxt = sec_r + 8'h01;
				end
			end
			default: begin
				sec_nxt = 8'h00;
				phase_nxt = sct_pkg::SCT_FIRST;
			end
		endcase
	end

	// new config copied as a fresh interval begins
	assign load_active = intv_end;

	// counter registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= '0;
			sec_r <= 8'h00;
			phase_r <= sct_pkg::SCT_FIRST;
		end else begin
			cnt_r <= cnt_nxt;
			sec_r <= sec_nxt;
			phase_r <= phase_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tick outputs

	// one-cycle high pulse after each second end, pin gated by enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_r <= 1'b0;
			pin_r <= 1'b0;
		end else begin
			tick_r <= sec_end;
			pin_r <= sec_end && pin_enable;
		end
	end

	assign second_tick = tick_r;
	assign second_pulse_pin = pin_r;

endmodule // sct_second_trim

`default_nettype wire

// ### logic/sct_params.svh
// sct_params.svh: constants of the second trim block
// assumes: included by bare name by the trim package and modules
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH

// oscillator cycles in one uncompensated second
`define SCT_SECOND_CYCLES 32768
// width of the cycle counter, holds up to 32768+127
`define SCT_CNT_W 16
// config word layout: interval in [15:8], value in [7:0]
`define SCT_CFG_W 16
`define SCT_INTV_MSB 15
`define SCT_INTV_LSB 8
`define SCT_VAL_MSB 7
`define SCT_VAL_LSB 0
// reset value of the config word: compensation off
`define SCT_CFG_RST 16'h0000

`endif

// ### logic/sct_pkg.sv
// sct_pkg.sv: types of the second trim block
// assumes: sct_params.svh is on the include path
`include "sct_params.svh"

package sct_pkg;
	typedef logic [`SCT_CNT_W-1:0] sct_cnt_t;
	typedef logic [7:0] sct_intv_t;
	typedef logic signed [7:0] sct_val_t;
	// second counter position within the interval
	typedef enum logic [0:0] {
		SCT_FIRST = 1'b0,
		SCT_OTHER = 1'b1
	} sct_phase_e;
endpackage

// ### logic/sct_cfg_latch.sv
// sct_cfg_latch.sv: software config word and the copy used by the divider
// assumes: cfg write strobe is synchronous to the oscillator clock
`timescale 1ns/10ps
`default_nettype none
`include "sct_params.svh"

module sct_cfg_latch (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// software side
	input wire logic cfg_we,
	input wire logic [`SCT_CFG_W-1:0] cfg_wdata,
	output logic [`SCT_CFG_W-1:0] cfg_rdata,
	// divider side
	input wire logic load_active,
	output logic [`SCT_CFG_W-1:0] cfg_active
);

	logic [`SCT_CFG_W-1:0] cfg_r;
	logic [`SCT_CFG_W-1:0] act_r;

	// software-held config word, interval and value together
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_r <= `SCT_CFG_RST;
		end else if (cfg_we) begin
			cfg_r <= cfg_wdata;
		end
	end

	// working copy only taken at an interval start
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			act_r <= `SCT_CFG_RST;
		end else if (load_active) begin
			act_r <= cfg_we ? cfg_wdata : cfg_r;
		end
	end

	assign cfg_rdata = cfg_r;
	assign cfg_active = act_r;

endmodule // sct_cfg_latch

`default_nettype wire

// ### bench/sct_second_trim_chk.sv
// sct_second_trim_chk.sv: port timing checks of the trim block
// assumes: bound to sct_second_trim, one clock
`timescale 1ns/10ps
`default_nettype none
`include "sct_params.svh"

module sct_second_trim_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// watched ports
	input wire logic cfg_we,
	input wire logic [`SCT_CFG_W-1:0] cfg_wdata,
	input wire logic [`SCT_CFG_W-1:0] cfg_rdata,
	input wire logic pin_enable,
	input wire logic second_tick,
	input wire logic second_pulse_pin
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	logic [15:0] gap_r;
	////////////////////////////////////////
	// cycles since the last tick
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			gap_r <= 16'h0000;
		else
			gap_r <= second_tick ? 16'h0001 : gap_r + 16'h0001;
	end
	tick_width_a: assert property (second_tick |=> !second_tick)
		else $error("tick too wide");
	pin_width_a: assert property (second_pulse_pin |=> !second_pulse_pin)
		else $error("pin pulse too wide");
	pin_source_a: assert property (second_pulse_pin |-> second_tick)
		else $error("pin pulse without tick");
	pin_follow_a: assert property (second_tick && pin_enable && $past(pin_enable)
		|-> second_pulse_pin)
		else $error("pin missed tick");
	cfg_store_a: assert property (cfg_we |=> cfg_rdata == $past(cfg_wdata))
		else $error("config not stored");
	cfg_hold_a: assert property (!cfg_we |=> $stable(cfg_rdata))
		else $error("config changed");
	gap_min_a: assert property (second_tick |-> gap_r >= 16'h7f80)
		else $error("second too short");
	gap_max_a: assert property (gap_r <= 16'h807f)
		else $error("second too long");
endmodule // sct_second_trim_chk

bind sct_second_trim sct_second_trim_chk chk (.clk(clk), .rstn(rstn), .cfg_we(cfg_we),
	.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pin_enable(pin_enable),
	.second_tick(second_tick), .second_pulse_pin(second_pulse_pin));
`default_nettype wire

// ### bench/sct_second_trim_bench.sv
// sct_second_trim_bench.sv: self-checking bench of the trim block
// assumes: checker bound by its own file
`timescale 1ns/10ps
`default_nettype none
`include "sct_params.svh"

module sct_second_trim_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cfg_we = 1'b0;
	logic [`SCT_CFG_W-1:0] cfg_wdata = 16'h0000;
	logic [`SCT_CFG_W-1:0] cfg_rdata;
	logic pin_enable = 1'b1;
	logic second_tick;
	logic second_pulse_pin;
	int n_errors = 0;
	int checks = 0;
	logic [31:0] gap;
	sct_second_trim dut (.clk(clk), .rstn(rstn), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .pin_enable(pin_enable), .second_tick(second_tick),
		.second_pulse_pin(second_pulse_pin));
	////////////////////////////////////////
	// 10 MHz clock
	initial forever #50 clk = ~clk;
	// compare and count
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// count falling edges up to the next tick
	task automatic to_tick();
		do begin
			@(negedge clk);
			gap++;
		end while (second_tick !== 1'b1 && gap < 40000);
	endtask
	// interval 2, value -128, read back
	task automatic t_write();
		@(negedge clk);
		cfg_we = 1'b1;
		cfg_wdata = 16'h0280;
		@(negedge clk);
		cfg_we = 1'b0;
		cfg_wdata = 16'h0000;
		@(negedge clk);
		gap = 3;
		check("cfg_rdata", 32'h0280, {16'h0000, cfg_rdata});
	endtask
	// seconds of the interval and the pin
	task automatic t_second(input logic [31:0] len, input logic pin);
		to_tick();
		check("second", len, gap);
		check("pin", {31'h0, pin}, {31'h0, second_pulse_pin});
		@(negedge clk);
		check("tick width", 32'h0, {31'h0, second_tick});
		gap = 1;
	endtask
	// verdict
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		t_write();
		t_second(32768, 1'b1);
		t_second(32640, 1'b1);
		pin_enable = 1'b0;
		t_second(32768, 1'b0);
		complete_run();
	end
	// watchdog
	initial begin
		#(99500 * 100);
		n_errors++;
		complete_run();
	end
endmodule // sct_second_trim_bench
`default_nettype wire
